/* File: pkg/eac_pkg.sv */
// Shared constants and types of the EEPROM access controller
package eac_pkg;
  // Clocking and programming time
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned RC_HZ         = 8_000_000;
  localparam int unsigned RC_DIV        = CLK_HZ / RC_HZ;
  localparam int unsigned WR_RC_CYC     = 26368;
  localparam int unsigned ATOM_TIME_US  = 3400;
  localparam int unsigned SPLIT_TIME_US = 1800;

  // Widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;

  // Control register field positions
  localparam int BIT_RE   = 0;
  localparam int BIT_PE   = 1;
  localparam int BIT_MPE  = 2;
  localparam int BIT_RIE  = 3;
  localparam int MODE_LSB = 4;
  localparam int MODE_MSB = 5;

  // Programming mode codes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE  = 2'h1;
  localparam logic [1:0] MODE_WRITE  = 2'h2;
  localparam logic [1:0] MODE_RSVD   = 2'h3;

  // Reset values and the erased byte value
  localparam logic [1:0]        MODE_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [DATA_W-1:0] ERASED   = 8'hff;

  // Cycle counts
  localparam logic [2:0] MPE_WIN  = 3'h4;
  localparam logic [2:0] STALL_WR = 3'h2;
  localparam logic [2:0] STALL_RD = 3'h4;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register select and engine states
  typedef enum logic [1:0] {SEL_CTRL, SEL_ADDR, SEL_DATA, SEL_NONE} eac_sel_t;
  typedef enum logic {NVM_IDLE, NVM_BUSY} eac_nvm_state_t;
endpackage

/* File: pkg/eac_nvm_if.sv */
// Link between the register front end and the array engine
`timescale 1ns/1ps
interface eac_nvm_if;
  logic        start;
  logic [1:0]  mode;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic        busy;
  logic [7:0]  rdata;
  modport ctrl (output start, mode, addr, wdata, input busy, rdata);
  modport nvm  (input start, mode, addr, wdata, output busy, rdata);
endinterface

/* File: core/eac_nvm_engine.sv */
// EEPROM array with its oscillator-timed programming engine
`timescale 1ns/1ps
module eac_nvm_engine #(
  parameter int unsigned P_WR_RC_CYC = eac_pkg::WR_RC_CYC
) (
  // Clock and power-on reset only
  input wire logic i_clk,
  input wire logic i_por_n,
  // Front end side
  eac_nvm_if.nvm   nv
);
  localparam int unsigned SPLIT_CYC =
    P_WR_RC_CYC * eac_pkg::SPLIT_TIME_US / eac_pkg::ATOM_TIME_US;
  localparam int CNT_W = $clog2(P_WR_RC_CYC + 1);
  localparam int DIV_W = $clog2(eac_pkg::RC_DIV + 1);

  logic [7:0]                 mem [0:4095];
  eac_pkg::eac_nvm_state_t    state_q;
  logic [DIV_W-1:0]           div_q;
  logic [CNT_W-1:0]           left_q;
  logic [1:0]                 op_q;
  logic [11:0]                addr_q;
  logic [7:0]                 data_q;
  logic                       tick;
  logic                       done;

  // Oscillator tick, restarted per operation so timing is repeatable
  assign tick = (div_q == DIV_W'(eac_pkg::RC_DIV - 1));
  assign done = (state_q == eac_pkg::NVM_BUSY) && tick
                && (left_q == CNT_W'(1));

  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      div_q <= '0;
    end else if (state_q == eac_pkg::NVM_IDLE || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // Only power-on clears this, so a system reset lets a write finish
  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      state_q <= eac_pkg::NVM_IDLE;
      left_q  <= '0;
      op_q    <= eac_pkg::MODE_RST;
      addr_q  <= eac_pkg::ADDR_RST;
      data_q  <= eac_pkg::DATA_RST;
    end else begin
      case (state_q)
        eac_pkg::NVM_IDLE: begin
          if (nv.start) begin
            state_q <= eac_pkg::NVM_BUSY;
            op_q    <= nv.mode;
            addr_q  <= nv.addr;
            data_q  <= nv.wdata;
            left_q  <= (nv.mode == eac_pkg::MODE_ATOMIC) ?
                       CNT_W'(P_WR_RC_CYC) : CNT_W'(SPLIT_CYC);
          end
        end
        eac_pkg::NVM_BUSY: begin
          if (done) begin
            state_q <= eac_pkg::NVM_IDLE;
          end else if (tick) begin
            left_q <= left_q - CNT_W'(1);
          end
        end
        default: state_q <= eac_pkg::NVM_IDLE;
      endcase
    end
  end

  // Cell update at the end of the programming time
  always_ff @(posedge i_clk) begin
    if (done) begin
      case (op_q)
        eac_pkg::MODE_ATOMIC: mem[addr_q] <= data_q;
        eac_pkg::MODE_ERASE:  mem[addr_q] <= eac_pkg::ERASED;
        eac_pkg::MODE_WRITE:  mem[addr_q] <= mem[addr_q] & data_q;
        default:              mem[addr_q] <= mem[addr_q];
      endcase
    end
  end

  assign nv.busy  = (state_q == eac_pkg::NVM_BUSY);
  assign nv.rdata = mem[nv.addr];

  a_busy_ends: assert property (@(posedge i_clk) disable iff (!i_por_n)
    done |=> !nv.busy)
    else $error("engine still busy after final tick");
endmodule

/* File: core/eac_eeprom_ctrl.sv */
// EEPROM access controller: bus registers, strobes, stalls, interlocks
`timescale 1ns/1ps
module eac_eeprom_ctrl #(
  parameter int unsigned P_WR_RC_CYC = eac_pkg::WR_RC_CYC
) (
  // Clock and resets
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_por_n,
  // AXI4-Lite write channels
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // AXI4-Lite read channels
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // Processor core side
  input  wire logic        i_global_irq_en,
  input  wire logic        i_flash_write_busy,
  output logic             o_ready_irq,
  output logic             o_cpu_stall
);
  eac_nvm_if nv ();

  logic        aw_got_q;
  logic [7:0]  awaddr_q;
  logic        w_got_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bpend_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [1:0]  mode_q;
  logic        rie_q;
  logic [2:0]  mpe_cnt_q;
  logic [11:0] addr_q;
  logic [7:0]  data_q;
  logic [2:0]  stall_q;
  logic        busy;
  logic        mpe;
  logic        wr_go;
  logic        ctrl_wr;
  logic        start;
  logic        rd_go;
  eac_pkg::eac_sel_t wsel;
  eac_pkg::eac_sel_t rsel;
  logic [7:0]  ctrl_view;

  // Address decode shared by both directions
  function automatic eac_pkg::eac_sel_t dec(input logic [7:0] a);
    case (a)
      eac_pkg::OFF_CTRL: dec = eac_pkg::SEL_CTRL;
      eac_pkg::OFF_ADDR: dec = eac_pkg::SEL_ADDR;
      eac_pkg::OFF_DATA: dec = eac_pkg::SEL_DATA;
      default:           dec = eac_pkg::SEL_NONE;
    endcase
  endfunction

  assign busy = nv.busy;
  assign mpe  = (mpe_cnt_q != 3'h0);
  assign wsel = dec(awaddr_q);
  assign rsel = dec({i_araddr[7:2], 2'b00});

  // Write channel acceptance; no new write until the response is gone
  assign o_awready = !aw_got_q && !bpend_q;
  assign o_wready  = !w_got_q && !bpend_q;
  assign wr_go     = aw_got_q && w_got_q && !bpend_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (wr_go) begin
      aw_got_q <= 1'b0;
    end else if (i_awvalid && o_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= {i_awaddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_got_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wr_go) begin
      w_got_q <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= i_wdata;
      wstrb_q <= i_wstrb;
    end
  end

  // Response is held back while the core is stalled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bpend_q <= 1'b0;
      bresp_q <= eac_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bpend_q <= 1'b1;
      bresp_q <= (wsel == eac_pkg::SEL_NONE) ? eac_pkg::RESP_SLVERR
                                             : eac_pkg::RESP_OKAY;
    end else if (o_bvalid && i_bready) begin
      bpend_q <= 1'b0;
    end
  end

  assign o_bvalid = bpend_q && (stall_q == 3'h0);
  assign o_bresp  = bresp_q;

  // Control register strobes
  assign ctrl_wr = wr_go && (wsel == eac_pkg::SEL_CTRL) && wstrb_q[0];
  assign start   = ctrl_wr && wdata_q[eac_pkg::BIT_PE]
                   && mpe
                   && !busy
                   && !i_flash_write_busy
                   && (mode_q != eac_pkg::MODE_RSVD);
  assign rd_go   = ctrl_wr && wdata_q[eac_pkg::BIT_RE] && !busy;

  // Master enable window, re-armed by every write of one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mpe_cnt_q <= 3'h0;
    end else if (ctrl_wr) begin
      mpe_cnt_q <= wdata_q[eac_pkg::BIT_MPE] ? eac_pkg::MPE_WIN : 3'h0;
    end else if (mpe) begin
      mpe_cnt_q <= mpe_cnt_q - 3'h1;
    end
  end

  // Mode survives a system reset that lands during programming
  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      mode_q <= eac_pkg::MODE_RST;
    end else if (!i_rst_n) begin
      if (!busy) begin
        mode_q <= eac_pkg::MODE_RST;
      end
    end else if (ctrl_wr && !busy) begin
      mode_q <= wdata_q[eac_pkg::MODE_MSB:eac_pkg::MODE_LSB];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rie_q <= 1'b0;
    end else if (ctrl_wr) begin
      rie_q <= wdata_q[eac_pkg::BIT_RIE];
    end
  end

  // Address is frozen while a write is under way
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_q <= eac_pkg::ADDR_RST;
    end else if (wr_go && wsel == eac_pkg::SEL_ADDR && !busy) begin
      if (wstrb_q[0]) begin
        addr_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        addr_q[11:8] <= wdata_q[11:8];
      end
    end
  end

  // Data register: software byte or fetched byte
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_q <= eac_pkg::DATA_RST;
    end else if (rd_go) begin
      data_q <= nv.rdata;
    end else if (wr_go && wsel == eac_pkg::SEL_DATA && wstrb_q[0]) begin
      data_q <= wdata_q[7:0];
    end
  end

  // Core stall after a strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stall_q <= 3'h0;
    end else if (start) begin
      stall_q <= eac_pkg::STALL_WR;
    end else if (rd_go) begin
      stall_q <= eac_pkg::STALL_RD;
    end else if (stall_q != 3'h0) begin
      stall_q <= stall_q - 3'h1;
    end
  end

  assign o_cpu_stall = (stall_q != 3'h0);
  assign o_ready_irq = rie_q && i_global_irq_en && !busy;

  // Engine hand-off; mode is the value held before this write
  assign nv.start = start;
  assign nv.mode  = mode_q;
  assign nv.addr  = addr_q;
  assign nv.wdata = data_q;

  // Read side: strobe bit shows the engine, read strobe reads as zero
  assign ctrl_view = {2'b00, mode_q, rie_q, mpe, busy, 1'b0};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= eac_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= eac_pkg::RESP_OKAY;
      case (rsel)
        eac_pkg::SEL_CTRL: rdata_q <= {24'h00_0000, ctrl_view};
        eac_pkg::SEL_ADDR: rdata_q <= {20'h0_0000, addr_q};
        eac_pkg::SEL_DATA: rdata_q <= {24'h00_0000, data_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= eac_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_arready = !rvalid_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

  eac_nvm_engine #(
    .P_WR_RC_CYC (P_WR_RC_CYC)
  ) u_engine (
    .i_clk   (i_clk),
    .i_por_n (i_por_n),
    .nv      (nv.nvm)
  );

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_rsv_zero: assert property (
    (i_arvalid && o_arready && rsel == eac_pkg::SEL_CTRL)
      |=> o_rdata[7:6] == 2'b00)
    else $error("reserved control bits read nonzero");

  a_mode_frozen: assert property (
    busy && $past(busy) |-> $stable(mode_q))
    else $error("mode changed while programming");

  a_mode_reset: assert property (
    @(posedge i_clk) disable iff (!i_por_n)
    (!i_rst_n && !busy) |=> mode_q == eac_pkg::MODE_RST)
    else $error("mode not cleared by reset");

  a_irq_off_busy: assert property (
    busy |-> !o_ready_irq)
    else $error("ready interrupt while programming");

  a_strobe_busy: assert property (
    start |=> busy)
    else $error("valid strobe did not start programming");

  // A control write with the enable bit clear ends the window early
  a_mpe_timeout: assert property (
    $fell(mpe) && !$past(ctrl_wr) |-> $past(mpe, 4))
    else $error("master enable cleared early");

  a_need_mpe: assert property (
    ctrl_wr && wdata_q[eac_pkg::BIT_PE] && !mpe |=> !$rose(busy))
    else $error("write started without master enable");

  a_flash_lock: assert property (
    ctrl_wr && i_flash_write_busy |=> !$rose(busy))
    else $error("programming started during flash write");

  a_wr_stall: assert property (
    start |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("write stall not two cycles");

  a_rd_stall: assert property (
    rd_go |=> o_cpu_stall [*4] ##1
      !o_cpu_stall && data_q == $past(nv.rdata, 5))
    else $error("read stall or data wrong");

  a_addr_locked: assert property (
    busy && $past(busy) |-> $stable(addr_q))
    else $error("address changed while programming");

  a_rsvd_mode: assert property (
    ctrl_wr && mode_q == eac_pkg::MODE_RSVD |=> !$rose(busy))
    else $error("reserved mode started programming");

  c_write_start: cover property (start ##[1:20] o_bvalid);
  c_read_byte:   cover property (rd_go ##5 o_bvalid);
  c_mpe_expire:  cover property ($fell(mpe) && !busy);
  c_rst_in_busy: cover property (@(posedge i_clk) disable iff (!i_por_n)
    !i_rst_n && busy);
endmodule

/* File: tb/eac_core_model.sv */
// Processor-side bus master that drives the controller registers
`timescale 1ns/1ps
module eac_core_model (
  // Clock
  input  wire logic        i_clk,
  // Write channels
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [7:0]       o_awaddr,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  output logic [31:0]      o_wdata,
  input  wire logic        i_bvalid,
  input  wire logic [1:0]  i_bresp,
  // Read channels
  output logic             o_arvalid,
  input  wire logic        i_arready,
  output logic [7:0]       o_araddr,
  input  wire logic        i_rvalid,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp
);
  // Idle bus at time zero
  initial begin
    o_awvalid = 1'b0;
    o_wvalid  = 1'b0;
    o_arvalid = 1'b0;
    o_awaddr  = 8'h00;
    o_wdata   = 32'h0;
    o_araddr  = 8'h00;
  end

  // One write; entered just after a rising edge, leaves just after one
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p  = 1'b1;
    o_awvalid <= 1'b1;
    o_awaddr  <= a;
    o_wvalid  <= 1'b1;
    o_wdata   <= d;
    while (aw_p || w_p) begin
      @(posedge i_clk);
      // Released payload is inverted so a stale value is never trusted
      if (aw_p && i_awready === 1'b1) begin
        aw_p = 1'b0;
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (w_p && i_wready === 1'b1) begin
        w_p = 1'b0;
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
    end
    do @(posedge i_clk); while (i_bvalid !== 1'b1);
    r = i_bresp;
  endtask

  // One read; the bench keeps rready high throughout
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    o_arvalid <= 1'b1;
    o_araddr  <= a;
    do @(posedge i_clk); while (i_arready !== 1'b1);
    o_arvalid <= 1'b0;
    o_araddr  <= ~a;
    while (i_rvalid !== 1'b1) @(posedge i_clk);
    d = i_rdata;
    r = i_rresp;
  endtask
endmodule

/* File: tb/test_eeprom_access_controller.sv */
// Self-checking bench of the EEPROM access controller
`timescale 1ns/1ps
module test_eeprom_access_controller;
  localparam int unsigned P   = 20;
  localparam int unsigned SPL = P * eac_pkg::SPLIT_TIME_US /
                                eac_pkg::ATOM_TIME_US;
  localparam int unsigned TOL = eac_pkg::RC_DIV + 8;
  localparam logic [7:0]  CT  = eac_pkg::OFF_CTRL;
  localparam logic [7:0]  AD  = eac_pkg::OFF_ADDR;
  localparam logic [7:0]  DA  = eac_pkg::OFF_DATA;
  // Mode, data, expected byte and oscillator ticks per row
  localparam logic [1:0]  MD[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  localparam logic [7:0]  DV[5] = '{8'h5a, 8'h00, 8'h3c, 8'h11, 8'h77};
  localparam logic [7:0]  EX[5] = '{8'h5a, 8'hff, 8'h3c, 8'h3c, 8'h3c};
  localparam int unsigned TK[5] = '{P, SPL, SPL, 0, 0};

  logic        i_clk;
  logic        rst_n;
  logic        por_n;
  logic        gie;
  logic        fbusy;
  logic        awvalid, awready, wvalid, wready, bvalid;
  logic        arvalid, arready, rvalid, irq, stall;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          stalls = 0;
  int          t0;
  int          n;

  eac_eeprom_ctrl #(.P_WR_RC_CYC(P)) dut (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_por_n(por_n),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(1'b1),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(1'b1),
    .o_rdata(rdata), .o_rresp(rresp), .i_global_irq_en(gie),
    .i_flash_write_busy(fbusy), .o_ready_irq(irq), .o_cpu_stall(stall));

  eac_core_model core (
    .i_clk(i_clk), .o_awvalid(awvalid), .i_awready(awready),
    .o_awaddr(awaddr), .o_wvalid(wvalid), .i_wready(wready),
    .o_wdata(wdata), .i_bvalid(bvalid), .i_bresp(bresp),
    .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr),
    .i_rvalid(rvalid), .i_rdata(rdata), .i_rresp(rresp));

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Cycle count, stall tally and hang guard
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (stall === 1'b1) stalls = stalls + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      $display("[ERR] %0t run did not finish", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    core.wr(a, d, rsp);
    chk({32'h0, rsp}, {32'h0, eac_pkg::RESP_OKAY});
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [31:0] e);
    core.rd(a, rd, rsp);
    chk({rsp, rd}, {eac_pkg::RESP_OKAY, e});
  endtask

  // Arm then strike; the interrupt-free core never splits the pair
  task automatic prog_start(input logic [1:0] m, input logic [7:0] d,
                            input logic f);
    logic [31:0] c;
    c = {26'h0, m, 4'h8};
    fbusy <= f;
    w(DA, {24'h0, d});
    w(CT, c | 32'hc0);
    chk({33'h0, irq}, 34'h1);
    w(CT, c | 32'h4);
    stalls = 0;
    w(CT, c | 32'h2);
    t0 = cyc;
  endtask

  // Ready interrupt rises when the strobe drops
  task automatic wait_done();
    while (irq !== 1'b1) @(posedge i_clk);
    n = cyc - t0;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    gie   = 1'b1;
    fbusy = 1'b0;
    repeat (20) @(posedge i_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge i_clk);
    reg_is(CT, 32'h0);
    core.rd(8'h0c, rd, rsp);
    chk({rsp, rd}, {eac_pkg::RESP_SLVERR, 32'h0});
    core.wr(8'h0c, 32'h1, rsp);
    chk({32'h0, rsp}, {32'h0, eac_pkg::RESP_SLVERR});
    w(AD, 32'hffffffff);
    reg_is(AD, 32'hfff);
    w(AD, 32'h5);
    stalls = 0;
    w(CT, 32'h2);
    reg_is(CT, 32'h0);
    w(CT, 32'h4);
    repeat (8) @(posedge i_clk);
    w(CT, 32'h2);
    reg_is(CT, 32'h0);
    chk(34'(stalls), 34'h0);
    for (int i = 0; i < 5; i++) begin
      prog_start(MD[i], DV[i], i == 4);
      if (i == 0) begin
        w(AD, 32'h9);
        w(CT, 32'h38);
        w(CT, 32'h9);
        reg_is(CT, 32'ha);
        reg_is(AD, 32'h5);
      end
      wait_done();
      chk(34'(stalls), TK[i] == 0 ? 34'h0 : 34'h2);
      chk({33'h0, TK[i] == 0 ? n == 0 :
           (n + TOL >= TK[i] * eac_pkg::RC_DIV &&
            n <= TK[i] * eac_pkg::RC_DIV + TOL)}, 34'h1);
      reg_is(CT, {26'h0, MD[i], 4'h8});
      stalls = 0;
      w(CT, {26'h0, MD[i], 4'h9});
      chk(34'(stalls), 34'h4);
      reg_is(DA, {24'h0, EX[i]});
    end
    gie <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk({33'h0, irq}, 34'h0);
    gie <= 1'b1;
    prog_start(eac_pkg::MODE_WRITE, 8'h0f, 1'b0);
    repeat (5) @(posedge i_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    rst_n <= 1'b1;
    @(posedge i_clk);
    reg_is(CT, 32'h22);
    do core.rd(CT, rd, rsp); while (rd[1] === 1'b1);
    reg_is(CT, 32'h20);
    w(AD, 32'h5);
    w(CT, 32'h21);
    reg_is(DA, 32'h0c);
    rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    rst_n <= 1'b1;
    @(posedge i_clk);
    reg_is(CT, 32'h0);
    end_sim();
  end
endmodule
